// ===== vdh_pkg.sv
// Purpose: constants, types and register map of the vector dispatch and halt save unit
// Assumes: one 100 MHz clock, AHB-Lite register slave with 32-bit data
// Notes:   register indices are scaled by four to give byte addresses
//
// Notes on behaviour
// - kernel stack invalid vectors at 08, no parameters, handler on interrupt stack.
// - power fail vectors at 0C, no parameters, raises priority to 1E.
// - access violation 20 and translation invalid 24 push address and status.
// - arithmetic condition vectors at 34 and pushes its type code.
// - change mode kernel..user at 40,44,48,4C push sign-extended operand word.
// - software level 2 vectors at 88, no parameters, used for asynchronous traps.
// - software level 3 at 8C, levels 4..15 at 90..BC, no parameters.
// - emulation start at C8, first part done clear, ten parameters.
// - external vector index comes from supplied value bits 15..2, range 100..FFFC.
// - supplied bit 0 clear gives priority 17,16,15,14 for request 3..0.
// - supplied bit 0 set forces new priority 17 whatever the request.
// - halt saves program counter into register 42, other state into 43.
// - halt status holds status longword, mapping enable bit, halt code, valid bit.
// - status bit 14 is 0 when valid, 1 when invalid; undefined after reset halt.
// - machine check at 04 pushes 6; passive release at 00 takes requesting level.
// - after halt save, status becomes 041F0000, interrupt stack, jump to 20040000.
package vdh_pkg;
  // vector offsets
  localparam logic [7:0] OFF_PASSIVE = 8'h00;
  localparam logic [7:0] OFF_MCHK    = 8'h04;
  localparam logic [7:0] OFF_KSNV    = 8'h08;
  localparam logic [7:0] OFF_PWRFAIL = 8'h0c;
  localparam logic [7:0] OFF_RSVD    = 8'h10;
  localparam logic [7:0] OFF_ACV     = 8'h20;
  localparam logic [7:0] OFF_TNV     = 8'h24;
  localparam logic [7:0] OFF_ARITH   = 8'h34;
  localparam logic [7:0] OFF_CHM     = 8'h40;
  localparam logic [7:0] OFF_SOFT    = 8'h80;
  localparam logic [7:0] OFF_EMUL    = 8'hc8;
  // parameter counts
  localparam logic [3:0] PRM_NONE  = 4'h0;
  localparam logic [3:0] PRM_ONE   = 4'h1;
  localparam logic [3:0] PRM_TWO   = 4'h2;
  localparam logic [3:0] PRM_MCHK  = 4'h6;
  localparam logic [3:0] PRM_EMUL  = 4'ha;
  // priority levels
  localparam logic [4:0] IPL_PWRFAIL = 5'h1e;
  localparam logic [4:0] IPL_HALT    = 5'h1f;
  localparam logic [4:0] IPL_EXT0    = 5'h14;
  localparam logic [4:0] IPL_FORCED  = 5'h17;
  // halt entry state and base register mask
  localparam logic [31:0] HALT_PSL   = 32'h041f_0000;
  localparam logic [31:0] HALT_PC    = 32'h2004_0000;
  localparam logic [31:0] BASE_MASK  = 32'h3fff_fe00;
  // register indices
  localparam logic [7:0] IDX_BASE   = 8'h00;
  localparam logic [7:0] IDX_IPL    = 8'h01;
  localparam logic [7:0] IDX_STAT   = 8'h02;
  localparam logic [7:0] IDX_CLEAR  = 8'h03;
  localparam logic [7:0] IDX_ENABLE = 8'h04;
  localparam logic [7:0] IDX_HALT_SAVED_PC  = 8'h2a;
  localparam logic [7:0] IDX_SAVST  = 8'h2b;
  // status bits
  localparam int ST_DISP = 0;
  localparam int ST_HALT = 1;
  localparam int ST_W    = 2;

  typedef enum logic [3:0] {
    EXC_PASSIVE = 4'h0, EXC_MCHK = 4'h1, EXC_KSNV = 4'h2, EXC_ACV = 4'h3,
    EXC_TNV = 4'h4, EXC_ARITH = 4'h5, EXC_CHANGE_MODE_KERNEL = 4'h6, EXC_CHANGE_MODE_EXECUTIVE = 4'h7,
    EXC_CHANGE_MODE_SUPERVISOR = 4'h8, EXC_CHANGE_MODE_USER = 4'h9, EXC_EMUL = 4'ha
  } vdh_exc_t;

  typedef enum logic [1:0] {S_IDLE = 2'b01, S_WAIT = 2'b10} vdh_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  params;
    logic [4:0]  interrupt_priority_level;
    logic        istack;
    logic        first_part_done;
  } vdh_disp_t;

  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] processor_status_longword;
    logic        mapping_enable;
    logic [5:0]  code;
    logic        invalid;
  } vdh_halt_t;
endpackage

// ===== vdh_dispatch.sv
// Purpose: exception and interrupt vector dispatch with hardware halt save
// Assumes: inputs synchronous to clk; the core takes one dispatch per disp_valid pulse
// Notes:   registers reached over AHB-Lite, zero wait states
`timescale 1ns/100ps
`default_nettype none
module vdh_dispatch (
  input  wire logic               clk,
  input  wire logic               reset,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic [31:0]             hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // synchronous exceptions from the core
  input  wire logic               exc_valid,
  input  wire vdh_pkg::vdh_exc_t  exc_kind,
  input  wire logic [4:0]         exc_level,
  // interrupt sources
  input  wire logic               power_fail,
  input  wire logic [15:1]        soft_req,
  input  wire logic [3:0]         ext_irq,
  input  wire logic               ext_vec_valid,
  input  wire logic [15:0]        ext_vec,
  // halt request with the state to save
  input  wire logic               halt_req,
  input  wire vdh_pkg::vdh_halt_t halt_state,
  // outputs to the core and to the external interrupt hardware
  output logic                    disp_valid,
  output vdh_pkg::vdh_disp_t      disp,
  output logic                    ext_ack,
  output logic [1:0]              ext_ack_level,
  output logic                    halt_done,
  output logic [31:0]             halt_new_psl,
  output logic [31:0]             halt_new_pc,
  output logic [4:0]              cur_ipl,
  output logic                    irq
);
  // -----------------------------------------------------------------
  // exception decode
  // -----------------------------------------------------------------
  function automatic vdh_pkg::vdh_disp_t exc_decode(
    input logic [3:0]  kind,
    input logic [31:0] base,
    input logic [4:0]  lvl,
    input logic [4:0]  ipl_now
  );
    vdh_pkg::vdh_disp_t r;
    logic [7:0]         off;
    r     = '0;
    r.interrupt_priority_level = ipl_now;
    off   = vdh_pkg::OFF_RSVD;
    case (kind)
      vdh_pkg::EXC_PASSIVE: begin
        off   = vdh_pkg::OFF_PASSIVE;
        r.interrupt_priority_level = lvl;
      end
      vdh_pkg::EXC_MCHK: begin
        off      = vdh_pkg::OFF_MCHK;
        r.params = vdh_pkg::PRM_MCHK;
      end
      vdh_pkg::EXC_KSNV: begin
        off      = vdh_pkg::OFF_KSNV;
        r.istack = 1'b1;
      end
      vdh_pkg::EXC_ACV: begin
        off      = vdh_pkg::OFF_ACV;
        r.params = vdh_pkg::PRM_TWO;
      end
      vdh_pkg::EXC_TNV: begin
        off      = vdh_pkg::OFF_TNV;
        r.params = vdh_pkg::PRM_TWO;
      end
      vdh_pkg::EXC_ARITH: begin
        off      = vdh_pkg::OFF_ARITH;
        r.params = vdh_pkg::PRM_ONE;
      end
      vdh_pkg::EXC_CHANGE_MODE_KERNEL, vdh_pkg::EXC_CHANGE_MODE_EXECUTIVE, vdh_pkg::EXC_CHANGE_MODE_SUPERVISOR, vdh_pkg::EXC_CHANGE_MODE_USER: begin
        // kernel..user sit on consecutive longwords
        off      = vdh_pkg::OFF_CHM + {2'b00, kind - vdh_pkg::EXC_CHANGE_MODE_KERNEL, 2'b00};
        r.params = vdh_pkg::PRM_ONE;
      end
      vdh_pkg::EXC_EMUL: begin
        off      = vdh_pkg::OFF_EMUL;
        r.params = vdh_pkg::PRM_EMUL;
        r.first_part_done    = 1'b0;
      end
      default: begin
        off = vdh_pkg::OFF_RSVD;
      end
    endcase
    r.addr = base + {24'h00_0000, off};
    return r;
  endfunction

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  vdh_pkg::vdh_state_t state;
  logic [31:0]         base;
  logic [31:0]         saved_pc;
  logic [31:0]         saved_status;
  logic [vdh_pkg::ST_W-1:0] status;
  logic [vdh_pkg::ST_W-1:0] enable;
  logic                rd_pend;
  logic                wr_pend;
  logic [7:0]          wr_idx;

  // -----------------------------------------------------------------
  // arbitration
  // -----------------------------------------------------------------
  logic [4:0] soft_lvl;
  logic [1:0] ext_idx;
  always_comb begin
    soft_lvl = '0;
    ext_idx  = '0;
    for (int i = 1; i < 16; i++) begin
      if (soft_req[i]) begin
        soft_lvl = 5'(i);
      end
    end
    for (int j = 0; j < 4; j++) begin
      if (ext_irq[j]) begin
        ext_idx = 2'(j);
      end
    end
  end

  wire logic [4:0] ext_lvl   = vdh_pkg::IPL_EXT0 + {3'b000, ext_idx};
  // levels rank power fail over external over software, so first match wins
  wire logic       take_pf   = power_fail && (vdh_pkg::IPL_PWRFAIL > cur_ipl);
  wire logic       take_ext  = !take_pf && (|ext_irq) && (ext_lvl > cur_ipl);
  wire logic       take_soft = !take_pf && !take_ext && (soft_lvl > cur_ipl);
  wire logic       idle      = (state == vdh_pkg::S_IDLE);
  wire logic       do_halt   = idle && halt_req;
  wire logic       do_exc    = idle && !halt_req && exc_valid;
  wire logic       do_int    = idle && !halt_req && !exc_valid;
  wire logic       do_vec    = (state == vdh_pkg::S_WAIT) && ext_vec_valid;

  vdh_pkg::vdh_disp_t exc_rec;
  vdh_pkg::vdh_disp_t pf_rec;
  vdh_pkg::vdh_disp_t soft_rec;
  vdh_pkg::vdh_disp_t vec_rec;
  always_comb begin
    exc_rec = exc_decode(exc_kind, base, exc_level, cur_ipl);
    pf_rec        = '0;
    pf_rec.addr   = base + {24'h00_0000, vdh_pkg::OFF_PWRFAIL};
    pf_rec.interrupt_priority_level    = vdh_pkg::IPL_PWRFAIL;
    soft_rec      = '0;
    // level n sits at 80 + 4n, so 2 lands on 88 and 15 on bc
    soft_rec.addr = base + {24'h00_0000, vdh_pkg::OFF_SOFT}
                  + {25'h0, soft_lvl, 2'b00};
    soft_rec.interrupt_priority_level  = soft_lvl;
    vec_rec       = '0;
    vec_rec.addr  = base + {16'h0000, ext_vec[15:2], 2'b00};
    // bit 0 covers daisy chains where another device may steal the grant
    vec_rec.interrupt_priority_level   = ext_vec[0] ? vdh_pkg::IPL_FORCED
                  : vdh_pkg::IPL_EXT0 + {3'b000, ext_ack_level};
  end

  wire logic next_disp_valid = do_exc || do_vec || (do_int && (take_pf || take_soft));
  vdh_pkg::vdh_disp_t next_disp;
  assign next_disp = do_vec  ? vec_rec
                   : do_exc  ? exc_rec
                   : take_pf ? pf_rec : soft_rec;

  // -----------------------------------------------------------------
  // dispatch sequencer
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state         <= vdh_pkg::S_IDLE;
      disp_valid    <= 1'b0;
      disp          <= '0;
      ext_ack       <= 1'b0;
      ext_ack_level <= '0;
    end else begin
      disp_valid <= next_disp_valid;
      if (next_disp_valid) begin
        disp <= next_disp;
      end
      case (state)
        vdh_pkg::S_IDLE: begin
          if (do_int && take_ext) begin
            ext_ack       <= 1'b1;
            ext_ack_level <= ext_idx;
            state         <= vdh_pkg::S_WAIT;
          end
        end
        vdh_pkg::S_WAIT: begin
          if (ext_vec_valid) begin
            ext_ack <= 1'b0;
            state   <= vdh_pkg::S_IDLE;
          end
        end
        default: begin
          state <= vdh_pkg::S_IDLE;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // halt save
  // -----------------------------------------------------------------
  wire logic [31:0] next_saved_status = {halt_state.processor_status_longword[31:16], halt_state.mapping_enable,
                                         halt_state.invalid, halt_state.code,
                                         halt_state.processor_status_longword[7:0]};
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      saved_pc     <= '0;
      saved_status <= '0;
      halt_done    <= 1'b0;
      halt_new_psl <= '0;
      halt_new_pc  <= '0;
    end else begin
      halt_done <= do_halt;
      if (do_halt) begin
        saved_pc     <= halt_state.pc;
        saved_status <= next_saved_status;
        halt_new_psl <= vdh_pkg::HALT_PSL;
        halt_new_pc  <= vdh_pkg::HALT_PC;
      end
    end
  end

  // -----------------------------------------------------------------
  // ahb-lite slave and registers
  // -----------------------------------------------------------------
  wire logic       ahb_take  = hsel && htrans[1] && hready;
  wire logic [7:0] ahb_idx   = haddr[9:2];
  wire logic       wr_ipl    = wr_pend && (wr_idx == vdh_pkg::IDX_IPL);
  wire logic [vdh_pkg::ST_W-1:0] events = {halt_done, disp_valid};
  wire logic [vdh_pkg::ST_W-1:0] clr    = (wr_pend && wr_idx == vdh_pkg::IDX_CLEAR)
                                          ? hwdata[vdh_pkg::ST_W-1:0] : '0;
  // a new event beats a clear in the same cycle
  wire logic [vdh_pkg::ST_W-1:0] next_status = (status & ~clr) | events;
  logic [31:0] next_rdata;
  always_comb begin
    case (ahb_idx)
      vdh_pkg::IDX_BASE:   next_rdata = base;
      vdh_pkg::IDX_IPL:    next_rdata = {27'h0, cur_ipl};
      vdh_pkg::IDX_STAT:   next_rdata = {30'h0, status};
      vdh_pkg::IDX_ENABLE: next_rdata = {30'h0, enable};
      vdh_pkg::IDX_HALT_SAVED_PC:  next_rdata = saved_pc;
      vdh_pkg::IDX_SAVST:  next_rdata = saved_status;
      default:             next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= '0;
      rd_pend   <= 1'b0;
      wr_pend   <= 1'b0;
      wr_idx    <= '0;
    end else begin
      rd_pend <= ahb_take && !hwrite;
      wr_pend <= ahb_take && hwrite;
      if (ahb_take) begin
        wr_idx <= ahb_idx;
      end
      if (ahb_take && !hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      base    <= '0;
      cur_ipl <= '0;
      status  <= '0;
      enable  <= '0;
      irq     <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= |(next_status & enable);
      if (wr_pend && wr_idx == vdh_pkg::IDX_BASE) begin
        base <= hwdata & vdh_pkg::BASE_MASK;
      end
      if (wr_pend && wr_idx == vdh_pkg::IDX_ENABLE) begin
        enable <= hwdata[vdh_pkg::ST_W-1:0];
      end
      // hardware level changes take precedence over a software write
      if (do_halt) begin
        cur_ipl <= vdh_pkg::IPL_HALT;
      end else if (next_disp_valid) begin
        cur_ipl <= next_disp.interrupt_priority_level;
      end else if (wr_ipl) begin
        cur_ipl <= hwdata[4:0];
      end
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_ksnv;
    do_exc && exc_kind == vdh_pkg::EXC_KSNV |=> disp_valid && disp.istack
      && disp.params == 4'h0 && disp.addr == base + 32'h0000_0008;
  endproperty
  a_ksnv: assert property (p_ksnv) else $error("ksnv dispatch wrong");

  property p_pwrfail;
    do_int && take_pf |=> disp_valid && disp.interrupt_priority_level == 5'h1e && cur_ipl == 5'h1e;
  endproperty
  a_pwrfail: assert property (p_pwrfail) else $error("power fail level wrong");

  property p_twoparm;
    do_exc && (exc_kind == vdh_pkg::EXC_ACV || exc_kind == vdh_pkg::EXC_TNV)
      |=> disp.params == 4'h2;
  endproperty
  a_twoparm: assert property (p_twoparm) else $error("fault params wrong");

  property p_chm;
    do_exc && exc_kind == vdh_pkg::EXC_CHANGE_MODE_SUPERVISOR |=> disp.addr == base + 32'h0000_0048
      && disp.params == 4'h1;
  endproperty
  a_chm: assert property (p_chm) else $error("change mode vector wrong");

  property p_emul;
    do_exc && exc_kind == vdh_pkg::EXC_EMUL |=> disp.params == 4'ha && !disp.first_part_done
      && disp.addr == base + 32'h0000_00c8;
  endproperty
  a_emul: assert property (p_emul) else $error("emulation start wrong");

  property p_forced;
    do_vec && ext_vec[0] |=> disp_valid && disp.interrupt_priority_level == 5'h17 && !ext_ack;
  endproperty
  a_forced: assert property (p_forced) else $error("forced level wrong");

  property p_reqlvl;
    do_vec && !ext_vec[0] |=> disp.interrupt_priority_level == 5'h14 + {3'b000, $past(ext_ack_level)}
      && disp.addr[15:0] == $past(base[15:0]) + {$past(ext_vec[15:2]), 2'b00};
  endproperty
  a_reqlvl: assert property (p_reqlvl) else $error("request level wrong");

  property p_halt;
    do_halt |=> halt_done && saved_pc == $past(halt_state.pc)
      && saved_status[14] == $past(halt_state.invalid)
      && halt_new_psl == 32'h041f_0000 && halt_new_pc == 32'h2004_0000;
  endproperty
  a_halt: assert property (p_halt) else $error("halt save wrong");

  property p_soft;
    do_int && take_soft |=> disp.interrupt_priority_level > $past(cur_ipl) && disp.addr[7:0] == 8'h80
      + {1'b0, disp.interrupt_priority_level, 2'b00};
  endproperty
  a_soft: assert property (p_soft) else $error("soft level vector wrong");
endmodule
`default_nettype wire

// ===== vdh_ext_model.sv
// Purpose: external bus interrupt hardware that answers a grant with a vector
// Assumes: the vector stands for one cycle, req_delay+1 cycles after the grant
// Notes:   ext_vec toggles when not presented so a stale vector never passes
`timescale 1ns/100ps
`default_nettype none
module vdh_ext_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        req_go,
  input  wire logic [1:0]  req_line,
  input  wire logic [15:0] req_vec,
  input  wire logic [3:0]  req_delay,
  input  wire logic        ext_ack,
  input  wire logic [1:0]  ext_ack_level,
  output logic [3:0]       ext_irq,
  output logic             ext_vec_valid,
  output logic [15:0]      ext_vec
);
  // ----------------------------------------
  // request, grant and vector
  // ----------------------------------------
  logic [3:0] cnt;
  logic       sent;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_irq       <= 4'h0;
      ext_vec_valid <= 1'b0;
      ext_vec       <= 16'h0;
      cnt           <= 4'h0;
      sent          <= 1'b0;
    end else begin
      ext_vec_valid <= 1'b0;
      ext_vec       <= ~ext_vec;
      if (req_go) begin
        ext_irq[req_line] <= 1'b1;
      end
      if (!ext_ack) begin
        sent <= 1'b0;
        cnt  <= 4'h0;
      end else if (!sent) begin
        if (cnt == req_delay) begin
          // the bench only hands vectors of 200..fffd
          ext_vec_valid <= 1'b1;
          ext_vec       <= req_vec;
          sent          <= 1'b1;
          // drop the line so the same request is not granted twice
          ext_irq[ext_ack_level] <= 1'b0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== test_vector_dispatch_and_halt_save.sv
// Purpose: self-checking bench of the vector dispatch and halt save unit
// Assumes: zero wait AHB-Lite slave, hready fed back from hreadyout
// Notes:   expected offsets and levels are written out, not taken from the package
`timescale 1ns/100ps
`default_nettype none
module test_vector_dispatch_and_halt_save;
  localparam logic [31:0] BASE = 32'h0000_4000;
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic              hsel = 1'b0;
  logic [31:0]       haddr = 32'h0;
  logic [31:0]       hwdata = 32'h0;
  logic [1:0]        htrans = 2'h0;
  logic              hwrite = 1'b0;
  logic              hready;
  logic [31:0]       hrdata;
  logic              hreadyout;
  logic              hresp;
  logic              exc_valid = 1'b0;
  vdh_pkg::vdh_exc_t exc_kind = vdh_pkg::EXC_PASSIVE;
  logic [4:0]        exc_level = 5'h03;
  logic              power_fail = 1'b0;
  logic [15:1]       soft_req = 15'h0;
  logic [3:0]        ext_irq;
  logic              ext_vec_valid;
  logic [15:0]       ext_vec;
  logic              halt_req = 1'b0;
  vdh_pkg::vdh_halt_t halt_state = '0;
  logic              disp_valid;
  vdh_pkg::vdh_disp_t disp;
  logic              ext_ack;
  logic [1:0]        ext_ack_level;
  logic              halt_done;
  logic [31:0]       halt_new_psl;
  logic [31:0]       halt_new_pc;
  logic [4:0]        cur_ipl;
  logic              irq;
  logic              req_go = 1'b0;
  logic [1:0]        req_line = 2'h0;
  logic [15:0]       req_vec = 16'h0;
  logic [3:0]        req_delay = 4'h0;
  logic [31:0]       rd;
  int                fail_count = 0;
  int                samples_checked = 0;
  logic [7:0]        offs [11] = '{8'h00, 8'h04, 8'h08, 8'h20, 8'h24, 8'h34, 8'h40, 8'h44,
                                   8'h48, 8'h4c, 8'hc8};
  logic [3:0]        prms [11] = '{4'h0, 4'h6, 4'h0, 4'h2, 4'h2, 4'h1, 4'h1, 4'h1, 4'h1,
                                   4'h1, 4'ha};

  always #5 clk = ~clk;
  assign hready = hreadyout;

  vdh_dispatch vdh_dispatch_inst (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .exc_valid(exc_valid),
    .exc_kind(exc_kind), .exc_level(exc_level), .power_fail(power_fail),
    .soft_req(soft_req), .ext_irq(ext_irq), .ext_vec_valid(ext_vec_valid),
    .ext_vec(ext_vec), .halt_req(halt_req), .halt_state(halt_state),
    .disp_valid(disp_valid), .disp(disp), .ext_ack(ext_ack), .ext_ack_level(ext_ack_level),
    .halt_done(halt_done), .halt_new_psl(halt_new_psl), .halt_new_pc(halt_new_pc),
    .cur_ipl(cur_ipl), .irq(irq));

  vdh_ext_model vdh_ext_model_inst (.clk(clk), .reset(reset), .req_go(req_go),
    .req_line(req_line), .req_vec(req_vec), .req_delay(req_delay), .ext_ack(ext_ack),
    .ext_ack_level(ext_ack_level), .ext_irq(ext_irq), .ext_vec_valid(ext_vec_valid),
    .ext_vec(ext_vec));

  // ----------------------------------------
  // bus cycles and compares
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(32'(hresp), 32'h0);
  endtask

  task automatic wait_disp(input logic [31:0] addr, input logic [3:0] prm,
                           input logic [4:0] interrupt_priority_level);
    int n;
    @(posedge clk);
    for (n = 0; n < 40 && disp_valid !== 1'b1; n++) @(posedge clk);
    chk(32'(disp_valid), 32'h1);
    chk(disp.addr, addr);
    chk(32'(disp.params), 32'(prm));
    chk(32'(disp.interrupt_priority_level), 32'(interrupt_priority_level));
    chk(32'(disp.first_part_done), 32'h0);
  endtask

  task automatic ext_run(input logic [1:0] l, input logic [15:0] v, input logic [3:0] dly,
                         input logic [4:0] interrupt_priority_level);
    int n;
    req_line <= l;
    req_vec <= v;
    req_delay <= dly;
    req_go <= 1'b1;
    @(posedge clk);
    req_go <= 1'b0;
    for (n = 0; n < 40 && ext_ack !== 1'b1; n++) @(posedge clk);
    chk(32'(ext_ack_level), 32'(l));
    wait_disp(BASE + {16'h0, v[15:2], 2'b00}, 4'h0, interrupt_priority_level);
    chk(32'(ext_ack), 32'h0);
  endtask

  task automatic halt_run(input vdh_pkg::vdh_halt_t st, input logic [31:0] exp);
    int n;
    halt_state <= st;
    halt_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
    for (n = 0; n < 40 && halt_done !== 1'b1; n++) @(posedge clk);
    chk(halt_new_psl, 32'h041f_0000);
    chk(halt_new_pc, 32'h2004_0000);
    chk(32'(cur_ipl), 32'h1f);
    rchk(32'ha8, st.pc);
    rchk(32'hac, exp);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop;
  end

  initial begin
    int i;
    int k;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rchk(32'h8, 32'h0);
    bus(1'b1, 32'ha8, 32'hffff_ffff);
    rchk(32'ha8, 32'h0);
    rchk(32'h40, 32'h0);
    bus(1'b1, 32'h0, BASE);
    // passive release last: it raises the level the other kinds keep
    for (i = 1; i <= 11; i++) begin
      k = i % 11;
      exc_valid <= 1'b1;
      exc_kind <= vdh_pkg::vdh_exc_t'(k);
      @(posedge clk);
      exc_valid <= 1'b0;
      wait_disp(BASE + 32'(offs[k]), prms[k], (k == 0) ? 5'h03 : 5'h00);
      if (k == 2) chk(32'(disp.istack), 32'h1);
    end
    exc_valid <= 1'b1;
    exc_kind <= vdh_pkg::vdh_exc_t'(4'hb);
    @(posedge clk);
    exc_valid <= 1'b0;
    wait_disp(BASE + 32'h10, 4'h0, 5'h03);
    bus(1'b1, 32'h4, 32'h0);
    for (i = 1; i <= 15; i++) begin
      soft_req <= 15'h1 << (i - 1);
      wait_disp(BASE + 32'h80 + 32'(4 * i), 4'h0, 5'(i));
    end
    soft_req <= 15'h0;
    bus(1'b1, 32'h4, 32'h0);
    power_fail <= 1'b1;
    soft_req <= 15'h4000;
    wait_disp(BASE + 32'h0c, 4'h0, 5'h1e);
    power_fail <= 1'b0;
    soft_req <= 15'h0;
    rchk(32'h4, 32'h1e);
    bus(1'b1, 32'h4, 32'h0);
    for (i = 0; i < 4; i++) begin
      ext_run(2'(i), 16'h0200 + 16'(i * 16'h0104), 4'(2 * i), 5'h14 + 5'(i));
    end
    bus(1'b1, 32'h4, 32'h0);
    ext_run(2'h1, 16'hfffd, 4'h3, 5'h17);
    bus(1'b1, 32'h10, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    bus(1'b1, 32'h10, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    rchk(32'h10, 32'h1);
    bus(1'b1, 32'hc, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    rchk(32'h8, 32'h0);
    halt_run('{32'h1234_5678, 32'habcd_00ef, 1'b1, 6'h2a, 1'b0}, 32'habcd_aaef);
    rchk(32'h8, 32'h2);
    halt_run('{32'h8000_0004, 32'h0000_0011, 1'b0, 6'h05, 1'b1}, 32'h0000_4511);
    report_and_stop;
  end
endmodule
`default_nettype wire
